/* rtl/mgmt_smbus_addr_protect.v */
// management serial target: scratch eeprom and thermal sensor behind strapped addresses
`timescale 1ns/10ps
`include "mgmt_smbus_defs.vh"
module mgmt_smbus_addr_protect (
  input wire clk_in, // 250 MHz core clock
  input wire reset_n_in, // async reset, active low
  input wire mgmt_serial_clock_in, // serial clock from host
  input wire mgmt_serial_data_in, // serial data line level
  output wire mgmt_serial_data_out, // serial data drive value
  output wire mgmt_serial_data_oe_out, // high while pulling data low
  input wire [2:0] eeprom_select_straps_in, // eeprom address straps
  input wire [1:0] sensor_select_straps_in, // sensor strap level when driven
  input wire [1:0] sensor_select_float_in, // pad reports strap floating
  input wire scratch_write_protect_in, // high blocks eeprom writes
  input wire [7:0] sensor_temp_in, // temperature reading
  output wire thermal_alert_n_out, // alert drive value
  output wire thermal_alert_n_oe_out // high while alert pulled low
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_WR = 3'h3;
  localparam ST_RD = 3'h4;
  localparam ST_RACK = 3'h5;

  reg rst_m_q;
  reg rst_q;
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_m_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_q <= rst_m_q;
    end
  end
  wire rst_n = rst_q;

  // every pin passes two flops; the serial clock is only sampled, never used as a clock
  reg [17:0] pin_m_q, pin_q;
  reg scl_prev_q, sda_prev_q;
  reg [7:0] temp_s_q, temp_q;
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_m_q <= `PIN_SYNC_RST;
      pin_q <= `PIN_SYNC_RST;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      temp_s_q <= 8'h00;
      temp_q <= 8'h00;
    end
    else
    begin
      pin_m_q <= {mgmt_serial_clock_in, mgmt_serial_data_in, eeprom_select_straps_in,
        sensor_select_straps_in, sensor_select_float_in, scratch_write_protect_in,
        sensor_temp_in};
      pin_q <= pin_m_q;
      scl_prev_q <= pin_q[17];
      sda_prev_q <= pin_q[16];
      // the temperature is a multi-bit word; accept it only once two samples agree
      temp_s_q <= pin_q[7:0];
      if (pin_q[7:0] == temp_s_q)
        temp_q <= temp_s_q;
    end
  end
  // idle levels in the reset value keep a false edge out after reset
  wire scl_s = pin_q[17];
  wire sda_s = pin_q[16];
  wire [2:0] ee_strap_s = pin_q[15:13];
  wire [1:0] ts_strap_s = pin_q[12:11];
  wire [1:0] ts_float_s = pin_q[10:9];
  wire wp_s = pin_q[8];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // tri-level decode: each sensor strap becomes one base-3 digit
  wire [1:0] ts_digit [0:1];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_strap
      assign ts_digit[gi] = ts_float_s[gi] ? `TS_LEVEL_FLOAT :
        (ts_strap_s[gi] ? `TS_LEVEL_HIGH : `TS_LEVEL_LOW);
    end
  endgenerate
  wire [3:0] ts_code = {ts_digit[1], 2'h0} - {2'h0, ts_digit[1]} + {2'h0, ts_digit[0]};
  wire [6:0] ee_addr = {`EE_ADDR_UPPER, ee_strap_s};
  wire [6:0] ts_addr = {`TS_ADDR_UPPER, ts_code};

  reg [7:0] ee_mem [0:`EE_DEPTH-1];
  reg [2:0] state_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg sel_ts_q, rd_q, ptr_phase_q, master_ack_q, sda_oe_q;
  reg [`EE_PTR_W-1:0] ee_ptr_q;
  reg [1:0] ts_ptr_q;
  reg [7:0] limit_q;
  reg alert_q;

  reg [7:0] rdata;
  always @*
  begin
    rdata = ee_mem[ee_ptr_q];
    if (sel_ts_q)
    begin
      case (ts_ptr_q)
        `TS_PTR_TEMP: rdata = temp_q;
        `TS_PTR_LIMIT: rdata = limit_q;
        `TS_PTR_STATUS: rdata = {7'h00, alert_q};
        default: rdata = 8'h00;
      endcase
    end
  end

  wire byte_done = (bit_q == `BYTE_BITS);
  wire wr_data = (state_q == ST_WR) & scl_fall & byte_done & ~ptr_phase_q;
  wire ee_wr = wr_data & ~sel_ts_q & ~wp_s;
  wire ts_limit_wr = wr_data & sel_ts_q & (ts_ptr_q == `TS_PTR_LIMIT);
  // status read clear fires when the status byte is loaded for shifting
  wire load_rd = scl_fall & (((state_q == ST_ACK) & rd_q) | ((state_q == ST_RACK) & master_ack_q));
  wire status_rd = load_rd & sel_ts_q & (ts_ptr_q == `TS_PTR_STATUS);

  always @(posedge clk_in)
  begin
    if (ee_wr)
      ee_mem[ee_ptr_q] <= shift_q;
  end

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      sel_ts_q <= 1'b0;
      rd_q <= 1'b0;
      ptr_phase_q <= 1'b0;
      master_ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ee_ptr_q <= {`EE_PTR_W{1'b0}};
      ts_ptr_q <= 2'h0;
      limit_q <= `TS_LIMIT_RST;
    end
    else if (start_cond)
    begin
      state_q <= ST_ADDR;
      bit_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_ADDR, ST_WR:
        begin
          if (scl_rise & ~byte_done)
          begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end
          else if (scl_fall & byte_done)
          begin
            bit_q <= 4'h0;
            if (state_q == ST_ADDR)
            begin
              if (shift_q[7:1] == ee_addr || shift_q[7:1] == ts_addr)
              begin
                sel_ts_q <= (shift_q[7:1] == ts_addr);
                rd_q <= shift_q[0];
                ptr_phase_q <= ~shift_q[0];
                sda_oe_q <= 1'b1;
                state_q <= ST_ACK;
              end
              else
                state_q <= ST_IDLE;
            end
            else
            begin
              // a protected eeprom write is still acknowledged, only the store is dropped
              sda_oe_q <= 1'b1;
              state_q <= ST_ACK;
              ptr_phase_q <= 1'b0;
              if (ptr_phase_q)
              begin
                if (sel_ts_q)
                  ts_ptr_q <= shift_q[1:0];
                else
                  ee_ptr_q <= shift_q[`EE_PTR_W-1:0];
              end
              else if (ts_limit_wr)
                limit_q <= shift_q;
              else if (~sel_ts_q)
                ee_ptr_q <= ee_ptr_q + 7'h01;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            if (rd_q)
            begin
              tx_q <= rdata;
              sda_oe_q <= ~rdata[7];
              bit_q <= 4'h1;
              state_q <= ST_RD;
            end
            else
            begin
              sda_oe_q <= 1'b0;
              bit_q <= 4'h0;
              state_q <= ST_WR;
            end
          end
        end
        ST_RD:
        begin
          if (scl_fall)
          begin
            if (byte_done)
            begin
              sda_oe_q <= 1'b0;
              state_q <= ST_RACK;
              if (~sel_ts_q)
                ee_ptr_q <= ee_ptr_q + 7'h01;
            end
            else
            begin
              sda_oe_q <= ~tx_q[3'h7 - bit_q[2:0]];
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
            master_ack_q <= ~sda_s;
          else if (scl_fall)
          begin
            if (master_ack_q)
            begin
              tx_q <= rdata;
              sda_oe_q <= ~rdata[7];
              bit_q <= 4'h1;
              state_q <= ST_RD;
            end
            else
              state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // alert latch is independent of the bus engine; a new event beats a read clear
  wire alert_set = (temp_q > limit_q);
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      alert_q <= 1'b0;
    else if (alert_set)
      alert_q <= 1'b1;
    else if (status_rd)
      alert_q <= 1'b0;
  end

  assign mgmt_serial_data_out = 1'b0;
  assign mgmt_serial_data_oe_out = sda_oe_q;
  assign thermal_alert_n_out = 1'b0;
  assign thermal_alert_n_oe_out = alert_q;
endmodule // mgmt_smbus_addr_protect

/* rtl/mgmt_smbus_defs.vh */
// constants for the management serial target block
`ifndef MGMT_SMBUS_DEFS_VH
`define MGMT_SMBUS_DEFS_VH
`define EE_ADDR_UPPER 4'hA
`define TS_ADDR_UPPER 3'h2
`define TS_LEVEL_LOW 2'h0
`define TS_LEVEL_HIGH 2'h1
`define TS_LEVEL_FLOAT 2'h2
`define EE_DEPTH 128
`define EE_PTR_W 7
`define TS_PTR_TEMP 2'h0
`define TS_PTR_LIMIT 2'h1
`define TS_PTR_STATUS 2'h2
`define TS_LIMIT_RST 8'h50
`define TS_STATUS_ALERT_BIT 0
`define BYTE_BITS 4'h8
`define PIN_SYNC_RST 18'h30000
`endif

/* tb/mgmt_smbus_monitor.sv */
// port assertions for the management serial target
`timescale 1ns/10ps
module mgmt_smbus_monitor (
  input wire clk_in, // clock
  input wire reset_n_in, // reset
  input wire mgmt_serial_clock_in, // serial clock
  input wire mgmt_serial_data_out, // data value
  input wire mgmt_serial_data_oe_out, // data pull
  input wire thermal_alert_n_out, // alert value
  input wire thermal_alert_n_oe_out // alert pull
);
  wire s = mgmt_serial_clock_in;
  wire d = mgmt_serial_data_oe_out;
  wire a = thermal_alert_n_oe_out;
  reg [4:0] hi_q;
  // a long run of serial clock high means no transfer is under way
  always @(posedge clk_in or negedge reset_n_in)
    if (!reset_n_in)
      hi_q <= 5'h00;
    else
      hi_q <= !s ? 5'h00 : hi_q + {4'h0, hi_q != 5'h1F};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_dval; !mgmt_serial_data_out; endproperty
  a_dval: assert property (p_dval) else $error("data value high");
  property p_aval; !thermal_alert_n_out; endproperty
  a_aval: assert property (p_aval) else $error("alert value high");
  property p_rel; $rose(reset_n_in) |-> (!d && !a)[*2]; endproperty
  a_rel: assert property (p_rel) else $error("pull after reset");
  property p_ack; $rose(d) |-> !s && !$past(s, 2); endproperty
  a_ack: assert property (p_ack) else $error("data pulled outside clock low");
  property p_len; $rose(d) |=> d[*3]; endproperty
  a_len: assert property (p_len) else $error("data pull too short");
  property p_hold; $rose(s) |=> $stable(d)[*3]; endproperty
  a_hold: assert property (p_hold) else $error("data moved while clock high");
  property p_idle; hi_q > 5'h14 |-> !d; endproperty
  a_idle: assert property (p_idle) else $error("data held on idle bus");
  property p_stk; hi_q > 5'h14 |-> !$fell(a); endproperty
  a_stk: assert property (p_stk) else $error("alert cleared without access");
endmodule // mgmt_smbus_monitor
bind mgmt_smbus_addr_protect mgmt_smbus_monitor mon (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .mgmt_serial_clock_in(mgmt_serial_clock_in), .mgmt_serial_data_out(mgmt_serial_data_out),
  .mgmt_serial_data_oe_out(mgmt_serial_data_oe_out), .thermal_alert_n_out(thermal_alert_n_out),
  .thermal_alert_n_oe_out(thermal_alert_n_oe_out));

/* tb/smbus_host_model.sv */
// host model: drives the serial clock, pulls data, reads bytes
`timescale 1ns/10ps
module smbus_host_model (
  input wire clk_in, // clock
  input wire dev_pull_in, // device pulls data
  output reg scl_out = 1'b1, // serial clock
  output wire sda_out, // data level
  output reg [7:0] got_out = 8'h00, // byte read
  output reg got_stb_out = 1'b0 // byte strobe
);
  reg pull_q = 1'b0;
  reg r;
  integer i;
  assign sda_out = ~(pull_q | dev_pull_in);
  task q;
    repeat (4) @(posedge clk_in);
  endtask
  // data moves a quarter period away from each clock edge for setup and hold
  task ph(input p, input c);
    begin
      q;
      pull_q <= p;
      q;
      scl_out <= c;
    end
  endtask
  task bx(input b, output o);
    begin
      ph(~b, 1'b1);
      q;
      o = sda_out;
      q;
      scl_out <= 1'b0;
    end
  endtask
  task start;
    begin
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b0);
    end
  endtask
  task stop;
    begin
      ph(1'b1, 1'b1);
      ph(1'b0, 1'b1);
    end
  endtask
  task wr_byte(input [7:0] b, output k);
    begin
      for (i = 7; i >= 0; i = i - 1)
        bx(b[i], r);
      bx(1'b1, r);
      k = ~r;
    end
  endtask
  task rd_byte(input more);
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        bx(1'b1, r);
        got_out <= {got_out[6:0], r};
      end
      bx(~more, r);
      got_stb_out <= 1'b1;
      @(posedge clk_in);
      got_stb_out <= 1'b0;
    end
  endtask
endmodule // smbus_host_model

/* tb/mgmt_smbus_addr_protect_tb.sv */
// bench for the management serial target
`timescale 1ns/10ps
module mgmt_smbus_addr_protect_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [2:0] ee_s = 3'h0;
  reg [1:0] ts_s = 2'h0;
  reg [1:0] ts_f = 2'h0;
  reg wp = 1'b0;
  reg [7:0] temp = 8'h20;
  wire scl, sda, doe, aoe, stb;
  wire [7:0] got;
  reg [7:0] expq[$];
  reg [7:0] d;
  reg [6:0] p, ea;
  reg ack;
  integer fail_count = 0;
  integer n_tests = 0;
  integer i;
  always #2 clk = ~clk;
  mgmt_smbus_addr_protect dut (.clk_in(clk), .reset_n_in(rst_n), .mgmt_serial_clock_in(scl),
    .mgmt_serial_data_in(sda), .mgmt_serial_data_out(), .mgmt_serial_data_oe_out(doe),
    .eeprom_select_straps_in(ee_s), .sensor_select_straps_in(ts_s),
    .sensor_select_float_in(ts_f), .scratch_write_protect_in(wp), .sensor_temp_in(temp),
    .thermal_alert_n_out(), .thermal_alert_n_oe_out(aoe));
  smbus_host_model host (.clk_in(clk), .dev_pull_in(doe), .scl_out(scl), .sda_out(sda),
    .got_out(got), .got_stb_out(stb));
  task chk_byte(input [7:0] e, input [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("[FAIL] read byte exp %h got %h", e, g);
      end
    end
  endtask
  task chk_ack(input e, input g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("[FAIL] acknowledge exp %b got %b", e, g);
      end
    end
  endtask
  task chk_alrt(input e, input g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        fail_count = fail_count + 1;
        $display("[FAIL] alert pull exp %b got %b", e, g);
      end
    end
  endtask
  always @(posedge clk)
    if (stb === 1'b1)
      chk_byte(expq.pop_front(), got);
  task sb(input [7:0] b, input e);
    begin
      host.wr_byte(b, ack);
      chk_ack(e, ack);
    end
  endtask
  task probe(input [6:0] a, input e);
    begin
      host.start;
      sb({a, 1'b0}, e);
      host.stop;
    end
  endtask
  task wr(input [6:0] a, input [7:0] ptr, input [7:0] v);
    begin
      host.start;
      sb({a, 1'b0}, 1'b1);
      sb(ptr, 1'b1);
      sb(v, 1'b1);
      host.stop;
    end
  endtask
  task rd(input [6:0] a, input [7:0] ptr, input [7:0] e);
    begin
      host.start;
      sb({a, 1'b0}, 1'b1);
      sb(ptr, 1'b1);
      host.start;
      sb({a, 1'b1}, 1'b1);
      expq.push_back(e);
      host.rd_byte(1'b0);
      host.stop;
    end
  endtask
  // two bytes in one read: the host acknowledges the first, so the pointer must advance
  task rd2(input [6:0] a, input [7:0] ptr, input [7:0] e0, input [7:0] e1);
    begin
      host.start;
      sb({a, 1'b0}, 1'b1);
      sb(ptr, 1'b1);
      host.start;
      sb({a, 1'b1}, 1'b1);
      expq.push_back(e0);
      expq.push_back(e1);
      host.rd_byte(1'b1);
      host.rd_byte(1'b0);
      host.stop;
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial
  begin
    i = $urandom(32'hde5cb1f2);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    ee_s <= 3'($urandom);
    p = 7'($urandom);
    d = 8'($urandom);
    repeat (12) @(posedge clk);
    ea = {4'hA, ee_s};
    rd(7'h20, 8'h01, 8'h50);
    wr(ea, {1'b0, p}, d);
    rd(ea, {1'b0, p}, d);
    wp <= 1'b1;
    wr(ea, {1'b0, p}, ~d);
    rd(ea, {1'b0, p}, d);
    wp <= 1'b0;
    wr(ea, {1'b0, p + 7'h01}, ~d);
    rd2(ea, {1'b0, p}, d, ~d);
    probe(ea ^ 7'h01, 1'b0);
    for (i = 0; i < 9; i = i + 1)
    begin
      ts_s <= {i / 3 == 1, i % 3 == 1};
      ts_f <= {i / 3 == 2, i % 3 == 2};
      repeat (8) @(posedge clk);
      probe({3'h2, 4'(i)}, 1'b1);
      probe({3'h2, 4'((i + 1) % 9)}, 1'b0);
    end
    temp <= 8'h60;
    repeat (20) @(posedge clk);
    chk_alrt(1'b1, aoe);
    temp <= 8'h10;
    rd(7'h28, 8'h00, 8'h10);
    chk_alrt(1'b1, aoe);
    rd(7'h28, 8'h02, 8'h01);
    repeat (8) @(posedge clk);
    chk_alrt(1'b0, aoe);
    wr(7'h28, 8'h01, 8'h30);
    rd(7'h28, 8'h01, 8'h30);
    rd(7'h28, 8'h03, 8'h00);
    chk_alrt(1'b0, aoe);
    temp <= 8'h40;
    repeat (20) @(posedge clk);
    chk_alrt(1'b1, aoe);
    repeat (20) @(posedge clk);
    conclude;
  end
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    conclude;
  end
endmodule // mgmt_smbus_addr_protect_tb
